// >>> design/move_return_exec.v
// execution of accumulator moves, literal load, no-op and returns
// Contract
// - accumulator copied to 7-bit file address, one cycle
// - literal loaded into accumulator, one cycle
// - interrupt return pops stack into program counter
// - interrupt return sets global interrupt enable
// - literal return loads literal into accumulator
// - literal return pops stack, two cycles
// - subroutine return pops stack, two cycles
`timescale 1ns/1ps
`include "exec_defines.vh"

module move_return_exec #(
  parameter CYCLE_DIV = `CYCLE_DIV,
  parameter STACK_DEPTH = `STACK_DEPTH
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [`INSTR_W-1:0] instr_in,
  input wire instr_valid_in,
  input wire push_in,
  input wire [`PC_W-1:0] push_addr_in,
  input wire gie_clear_in,
  output reg ready_out,
  output reg cycle_tick_out,
  output reg done_out,
  output reg unhandled_out,
  output reg [`DATA_W-1:0] w_out,
  output reg [`PC_W-1:0] pc_out,
  output reg global_interrupt_enable_out,
  output reg file_we_out,
  output reg [`FADDR_W-1:0] file_addr_out,
  output reg [`DATA_W-1:0] file_wdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle divider
  reg [`DIV_W-1:0] div_q;
  reg [`DIV_W-1:0] div_d;
  localparam integer DIV_LAST_I = CYCLE_DIV - 1;
  localparam [`DIV_W-1:0] DIV_LAST = DIV_LAST_I[`DIV_W-1:0];

  always @*
  begin
    div_d = div_q + {{(`DIV_W-1){1'b0}}, 1'b1};
    if (div_q == DIV_LAST)
    begin
      div_d = `DIV_RESET;
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_q <= `DIV_RESET;
      cycle_tick_out <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      cycle_tick_out <= (div_q == DIV_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_to_file;
  wire is_load_lit;
  wire is_ret_lit;
  wire is_nop;
  wire is_ret_int;
  wire is_ret_sub;
  wire is_return;
  wire take;
  wire [`DATA_W-1:0] literal;
  wire [`PC_W-1:0] top_of_stack_entry;

  assign is_to_file = (instr_in & `MSK_TO_FILE) == `ENC_TO_FILE;
  assign is_load_lit = (instr_in & `MSK_LIT) == `ENC_LOAD_LIT;
  assign is_ret_lit = (instr_in & `MSK_LIT) == `ENC_RET_LIT;
  assign is_nop = (instr_in & `MSK_NOP) == `ENC_NOP;
  assign is_ret_int = (instr_in & `MSK_EXACT) == `ENC_RET_INT;
  assign is_ret_sub = (instr_in & `MSK_EXACT) == `ENC_RET_SUB;
  assign is_return = is_ret_int || is_ret_sub || is_ret_lit;
  assign literal = instr_in[`DATA_W-1:0];
  assign take = cycle_tick_out && ready_out && instr_valid_in;

  ////////////////////////////////////////////////////////////////////////////
  // stack
  wire pop;

  assign pop = take && is_return;

  return_stack #(
    .WIDTH(`PC_W),
    .DEPTH(STACK_DEPTH),
    .PTR_W(`STACK_PTR_W)
  ) u_stack (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .push_in(push_in),
    .pop_in(pop),
    .push_data_in(push_addr_in),
    .top_of_stack_entry_out(top_of_stack_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execute
  reg second_q;
  reg second_d;
  reg ready_d;
  reg done_d;
  reg unhandled_d;
  reg [`DATA_W-1:0] w_d;
  reg [`PC_W-1:0] pc_d;
  reg gie_d;
  reg file_we_d;
  reg [`FADDR_W-1:0] file_addr_d;
  reg [`DATA_W-1:0] file_wdata_d;

  always @*
  begin
    second_d = second_q;
    ready_d = ready_out;
    done_d = 1'b0;
    unhandled_d = 1'b0;
    w_d = w_out;
    pc_d = pc_out;
    gie_d = global_interrupt_enable_out;
    file_we_d = 1'b0;
    file_addr_d = file_addr_out;
    file_wdata_d = file_wdata_out;
    if (gie_clear_in)
    begin
      gie_d = 1'b0;
    end
    if (cycle_tick_out && second_q)
    begin
      second_d = 1'b0;
      ready_d = 1'b1;
      done_d = 1'b1;
    end
    else if (take)
    begin
      if (is_to_file)
      begin
        file_we_d = 1'b1;
        file_addr_d = instr_in[`FADDR_W-1:0];
        file_wdata_d = w_out;
        pc_d = pc_out + {{(`PC_W-1){1'b0}}, 1'b1};
        done_d = 1'b1;
      end
      else if (is_load_lit)
      begin
        w_d = literal;
        pc_d = pc_out + {{(`PC_W-1){1'b0}}, 1'b1};
        done_d = 1'b1;
      end
      else if (is_return)
      begin
        pc_d = top_of_stack_entry;
        second_d = 1'b1;
        ready_d = 1'b0;
        if (is_ret_lit)
        begin
          w_d = literal;
        end
        if (is_ret_int)
        begin
          gie_d = 1'b1;
        end
      end
      else if (is_nop)
      begin
        pc_d = pc_out + {{(`PC_W-1){1'b0}}, 1'b1};
        done_d = 1'b1;
      end
      else
      begin
        unhandled_d = 1'b1;
      end
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      second_q <= 1'b0;
      ready_out <= 1'b1;
      done_out <= 1'b0;
      unhandled_out <= 1'b0;
      w_out <= `W_RESET;
      pc_out <= `PC_RESET;
      global_interrupt_enable_out <= `GIE_RESET;
      file_we_out <= 1'b0;
      file_addr_out <= {`FADDR_W{1'b0}};
      file_wdata_out <= `W_RESET;
    end
    else
    begin
      second_q <= second_d;
      ready_out <= ready_d;
      done_out <= done_d;
      unhandled_out <= unhandled_d;
      w_out <= w_d;
      pc_out <= pc_d;
      global_interrupt_enable_out <= gie_d;
      file_we_out <= file_we_d;
      file_addr_out <= file_addr_d;
      file_wdata_out <= file_wdata_d;
    end
  end

endmodule // move_return_exec

// >>> design/exec_defines.vh
// constants for the move and return instruction group
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

`define INSTR_W 14
`define PC_W 13
`define DATA_W 8
`define FADDR_W 7
`define STACK_DEPTH 8
`define STACK_PTR_W 3
`define CYCLE_DIV 4
`define DIV_W 3

`define PC_RESET 13'h0000
`define W_RESET 8'h00
`define GIE_RESET 1'b0
`define DIV_RESET 3'h0

`define ENC_TO_FILE 14'h0080
`define MSK_TO_FILE 14'h3F80
`define ENC_LOAD_LIT 14'h3000
`define ENC_RET_LIT 14'h3400
`define MSK_LIT 14'h3C00
`define ENC_NOP 14'h0000
`define MSK_NOP 14'h3F9F
`define ENC_RET_INT 14'h0009
`define ENC_RET_SUB 14'h0008
`define MSK_EXACT 14'h3FFF

`endif

// >>> design/return_stack.v
// circular hardware return stack with push and pop
`timescale 1ns/1ps
`include "exec_defines.vh"

module return_stack #(
  parameter WIDTH = `PC_W,
  parameter DEPTH = `STACK_DEPTH,
  parameter PTR_W = `STACK_PTR_W
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire push_in,
  input wire pop_in,
  input wire [WIDTH-1:0] push_data_in,
  output wire [WIDTH-1:0] top_of_stack_entry_out
);

  reg [PTR_W-1:0] ptr_q;
  reg [PTR_W-1:0] ptr_d;
  reg [WIDTH-1:0] entry_q [0:DEPTH-1];
  wire [PTR_W-1:0] top_idx;
  wire [PTR_W-1:0] wr_idx;

  assign top_idx = ptr_q - {{(PTR_W-1){1'b0}}, 1'b1};
  assign wr_idx = pop_in ? top_idx : ptr_q;
  assign top_of_stack_entry_out = entry_q[top_idx];

  ////////////////////////////////////////////////////////////////////////////
  // pointer: push and pop together replace the top entry
  always @*
  begin
    ptr_d = ptr_q;
    if (push_in && !pop_in)
    begin
      ptr_d = ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
    end
    else if (pop_in && !push_in)
    begin
      ptr_d = top_idx;
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ptr_q <= {PTR_W{1'b0}};
    end
    else
    begin
      ptr_q <= ptr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entries
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      localparam integer IDX_I = gi;
      localparam [PTR_W-1:0] IDX = IDX_I[PTR_W-1:0];
      always @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          entry_q[gi] <= {WIDTH{1'b0}};
        end
        else if (push_in && (wr_idx == IDX))
        begin
          entry_q[gi] <= push_data_in;
        end
      end
    end
  endgenerate

endmodule // return_stack

// >>> verif/move_return_exec_chk.sv
// checker for the move and return group
`timescale 1ns/1ps
module move_return_exec_chk #(parameter CYCLE_DIV = 4, parameter STACK_DEPTH = 8) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [13:0] instr_in,
  input wire instr_valid_in,
  input wire gie_clear_in,
  input wire ready_out,
  input wire cycle_tick_out,
  input wire done_out,
  input wire [7:0] w_out,
  input wire [12:0] pc_out,
  input wire global_interrupt_enable_out,
  input wire file_we_out,
  input wire [6:0] file_addr_out,
  input wire [7:0] file_wdata_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire take = cycle_tick_out && ready_out && instr_valid_in;
  wire lit_ret = (instr_in & 14'h3C00) == 14'h3400;
  wire ret = lit_ret || instr_in == 14'h0009 || instr_in == 14'h0008;
  a_file_copy: assert property (take && (instr_in & 14'h3F80) == 14'h0080 |=>
    file_we_out && file_addr_out == $past(instr_in[6:0]) && file_wdata_out == $past(w_out))
    else $error("store to file wrong");
  a_we_pulse: assert property (file_we_out |=> !file_we_out)
    else $error("write strobe too long");
  a_lit_load: assert property (take && (instr_in & 14'h3C00) == 14'h3000 |=>
    w_out == $past(instr_in[7:0]) && pc_out == $past(pc_out) + 13'h1 && done_out)
    else $error("literal load wrong");
  a_ret_hold: assert property (take && ret |=> ##1 $stable(pc_out) [*4])
    else $error("pc moved during return");
  a_enable_set: assert property (take && instr_in == 14'h0009 |=>
    global_interrupt_enable_out && !ready_out)
    else $error("enable not set");
  a_lit_ret_w: assert property (take && lit_ret |=> w_out == $past(instr_in[7:0]))
    else $error("literal return value wrong");
  a_ret_busy: assert property (take && ret |=> (!ready_out && !done_out) [*3]
    ##1 !ready_out ##1 (ready_out && done_out))
    else $error("return length wrong");
  a_enable_kept: assert property (take && instr_in == 14'h0008 && !gie_clear_in |=>
    $stable(global_interrupt_enable_out))
    else $error("enable changed by return");
  a_nop_still: assert property (take && (instr_in & 14'h3F9F) == 14'h0000 |=>
    $stable(w_out) && !file_we_out && pc_out == $past(pc_out) + 13'h1 && done_out)
    else $error("no-op changed state");
endmodule // move_return_exec_chk

bind move_return_exec move_return_exec_chk #(.CYCLE_DIV(CYCLE_DIV), .STACK_DEPTH(STACK_DEPTH))
  chk_i (
  .core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in),
  .instr_in(instr_in),
  .instr_valid_in(instr_valid_in),
  .gie_clear_in(gie_clear_in),
  .ready_out(ready_out),
  .cycle_tick_out(cycle_tick_out),
  .done_out(done_out),
  .w_out(w_out),
  .pc_out(pc_out),
  .global_interrupt_enable_out(global_interrupt_enable_out),
  .file_we_out(file_we_out),
  .file_addr_out(file_addr_out),
  .file_wdata_out(file_wdata_out)
);

// >>> verif/move_return_exec_tb.sv
// bench for the move and return group
`timescale 1ns/1ps
module move_return_exec_tb;
  reg core_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg [13:0] instr_in = 14'h0000;
  reg instr_valid_in = 1'b0;
  reg push_in = 1'b0;
  reg [12:0] push_addr_in = 13'h0000;
  reg gie_clear_in = 1'b0;
  wire ready_out, cycle_tick_out, done_out, unhandled_out, file_we_out;
  wire global_interrupt_enable_out;
  wire [7:0] w_out, file_wdata_out;
  wire [12:0] pc_out;
  wire [6:0] file_addr_out;
  integer errors = 0;
  integer tests_run = 0;
  integer cycles = 0;
  reg [12:0] pc0;
  reg [7:0] wexp = 8'h00;
  always #25 core_clk_in = ~core_clk_in;
  move_return_exec uut (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .instr_in(instr_in),
    .instr_valid_in(instr_valid_in),
    .push_in(push_in),
    .push_addr_in(push_addr_in),
    .gie_clear_in(gie_clear_in),
    .ready_out(ready_out),
    .cycle_tick_out(cycle_tick_out),
    .done_out(done_out),
    .unhandled_out(unhandled_out),
    .w_out(w_out),
    .pc_out(pc_out),
    .global_interrupt_enable_out(global_interrupt_enable_out),
    .file_we_out(file_we_out),
    .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out)
  );
  task chk(input [12:0] got, input [12:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task issue(input [13:0] op);
    integer n;
    begin
      n = 0;
      @(posedge core_clk_in);
      instr_in <= op;
      instr_valid_in <= 1'b1;
      do
      begin
        @(posedge core_clk_in);
        n = n + 1;
      end
      while (!(cycle_tick_out && ready_out) && n < 20);
      if (n >= 20)
      begin
        errors = errors + 1;
        $display("mismatch at %0t: instruction not taken", $time);
      end
      instr_valid_in <= 1'b0;
      pc0 = pc_out;
      #1;
    end
  endtask
  task t_load(input [7:0] k);
    begin
      issue(14'h3000 | k);
      wexp = k;
      chk(w_out, k);
      chk(done_out, 1'b1);
      chk(pc_out, pc0 + 13'h1);
    end
  endtask
  task t_file(input [6:0] a);
    begin
      issue(14'h0080 | a);
      chk(file_we_out, 1'b1);
      chk(file_addr_out, a);
      chk(file_wdata_out, wexp);
      chk(pc_out, pc0 + 13'h1);
      @(posedge core_clk_in);
      #1;
      chk(file_we_out, 1'b0);
    end
  endtask
  task t_nop;
    begin
      issue(14'h0060);
      chk(w_out, wexp);
      chk(file_we_out, 1'b0);
      chk(pc_out, pc0 + 13'h1);
      chk(done_out, 1'b1);
      chk(unhandled_out, 1'b0);
      chk(cycle_tick_out, 1'b0);
      repeat (3) @(posedge core_clk_in);
      #1;
      chk(cycle_tick_out, 1'b1);
    end
  endtask
  task t_ret(input [13:0] op, input [12:0] a, input g, input [7:0] wv);
    begin
      @(posedge core_clk_in);
      push_addr_in <= a;
      push_in <= 1'b1;
      @(posedge core_clk_in);
      push_in <= 1'b0;
      issue(op);
      chk(pc_out, a);
      chk(global_interrupt_enable_out, g);
      chk(w_out, wv);
      chk(ready_out, 1'b0);
      repeat (4) @(posedge core_clk_in);
      #1;
      chk(done_out, 1'b1);
      chk(ready_out, 1'b1);
      chk(pc_out, a);
    end
  endtask
  task end_sim;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge core_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      $display("mismatch at %0t: run timed out", $time);
      end_sim;
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    #1;
    chk(pc_out, 13'h0000);
    chk(global_interrupt_enable_out, 1'b0);
    t_load(8'h5A);
    t_file(7'h7F);
    t_load(8'hFF);
    t_file(7'h00);
    t_load(8'h00);
    t_nop;
    t_ret(14'h0009, 13'h1ABC, 1'b1, 8'h00);
    t_ret(14'h0008, 13'h1FFF, 1'b1, 8'h00);
    @(posedge core_clk_in);
    gie_clear_in <= 1'b1;
    @(posedge core_clk_in);
    gie_clear_in <= 1'b0;
    t_ret(14'h34C3, 13'h0123, 1'b0, 8'hC3);
    end_sim;
  end
endmodule // move_return_exec_tb
